/* File: core_arith_logic_ops.sv */
/*
 * Arithmetic and logic execution unit with its own status flags.
 * Assumes the decoder presents operands with op_valid for one cycle
 * and waits while busy_reg is high; word operands are registered at the take.
 */
`timescale 1ns/1ps
`default_nettype none
`include "core_alu_cfg.svh"

module core_arith_logic_ops (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                op_valid,
    input  wire core_alu_pkg::op_t   op_code,
    input  wire logic                op_use_imm,
    input  wire logic [7:0]          dst_val,
    input  wire logic [7:0]          dst_hi_val,
    input  wire logic [7:0]          src_val,
    input  wire logic [7:0]          imm_val,
    output var  logic                busy_reg,
    output var  logic                done_reg,
    output var  logic                word_reg,
    output var  logic [7:0]          result_lo_reg,
    output var  logic [7:0]          result_hi_reg,
    output var  logic [`FLAG_W-1:0]  flags_reg
);
    core_alu_pkg::state_t state_reg;
    core_alu_pkg::state_t state_next;
    logic                 take;
    logic                 is_word;
    logic                 word_minus_reg;
    logic [15:0]          word_in;
    logic [15:0]          word_in_reg;
    logic [15:0]          word_res_reg;
    logic [15:0]          word_res_next;
    logic [`FLAG_W-1:0]   word_flags;
    logic                 word_v;
    logic                 word_c;

    alu_byte_if byte_if ();

    arith_byte_unit byte_unit (
        .port_if (byte_if.unit)
    );

    // Immediate masks always feed the bit set and clear forms
    assign byte_if.op  = op_code;
    assign byte_if.a   = dst_val;
    assign byte_if.b   = (op_use_imm ||
                          op_code == core_alu_pkg::op_set_selected_bits ||
                          op_code == core_alu_pkg::op_clear_selected_bits)
                         ? imm_val : src_val;
    assign byte_if.cin = flags_reg[`FLAG_C];

    assign is_word = (op_code == core_alu_pkg::op_word_plus_immediate) ||
                     (op_code == core_alu_pkg::op_word_minus_immediate);
    // Requests during the second word cycle are ignored
    assign take    = op_valid && (state_reg == core_alu_pkg::st_idle);
    assign word_in = {dst_hi_val, dst_val};

    always_comb begin
        if (op_code == core_alu_pkg::op_word_minus_immediate) begin
            word_res_next = 16'(word_in - {8'h00, imm_val});
        end else begin
            word_res_next = 16'(word_in + {8'h00, imm_val});
        end
    end

    // Word carry and overflow from the stored operand and result high bits, zero from the whole result
    always_comb begin
        if (word_minus_reg) begin
            word_v = word_in_reg[15] & ~word_res_reg[15];
            word_c = word_res_reg[15] & ~word_in_reg[15];
        end else begin
            word_v = ~word_in_reg[15] & word_res_reg[15];
            word_c = ~word_res_reg[15] & word_in_reg[15];
        end
        word_flags          = `FLAGS_RST;
        word_flags[`FLAG_C] = word_c;
        word_flags[`FLAG_Z] = (word_res_reg == `WORD_ZERO);
        word_flags[`FLAG_N] = word_res_reg[15];
        word_flags[`FLAG_V] = word_v;
        word_flags[`FLAG_S] = word_res_reg[15] ^ word_v;
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            core_alu_pkg::st_idle: begin
                if (take && is_word) begin
                    state_next = core_alu_pkg::st_word_hi;
                end
            end
            core_alu_pkg::st_word_hi: state_next = core_alu_pkg::st_idle;
            default:                  state_next = core_alu_pkg::st_idle;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= core_alu_pkg::st_idle;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg  <= (state_next == core_alu_pkg::st_word_hi);
        end
    end

    // Word operands held for the second cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            word_in_reg    <= `WORD_ZERO;
            word_res_reg   <= `WORD_ZERO;
            word_minus_reg <= 1'b0;
        end else if (take && is_word) begin
            word_in_reg    <= word_in;
            word_res_reg   <= word_res_next;
            word_minus_reg <= (op_code ==
                               core_alu_pkg::op_word_minus_immediate);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_reg      <= 1'b0;
            word_reg      <= 1'b0;
            result_lo_reg <= `BYTE_RST;
            result_hi_reg <= `BYTE_RST;
        end else if (state_reg == core_alu_pkg::st_word_hi) begin
            done_reg      <= 1'b1;
            word_reg      <= 1'b1;
            result_lo_reg <= word_res_reg[7:0];
            result_hi_reg <= word_res_reg[15:8];
        end else begin
            done_reg      <= take && !is_word;
            word_reg      <= 1'b0;
            if (take && !is_word) begin
                result_lo_reg <= byte_if.result;
            end
        end
    end

    // Merge keeps every flag outside the update mask
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_reg <= `FLAGS_RST;
        end else if (state_reg == core_alu_pkg::st_word_hi) begin
            flags_reg <= (flags_reg & ~`UPD_WORD) |
                         (word_flags & `UPD_WORD);
        end else if (take && !is_word) begin
            flags_reg <= (flags_reg & ~byte_if.flags_upd) |
                         (byte_if.flags_new & byte_if.flags_upd);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence byte_take(core_alu_pkg::op_t o);
        take && op_code == o;
    endsequence

    a_add_result: assert property (
        byte_take(core_alu_pkg::op_add) |=> done_reg &&
        result_lo_reg == 8'($past(dst_val) + $past(byte_if.b)))
        else $error("add result or timing wrong");
    a_word_two_clk: assert property (
        take && is_word |=> !done_reg && busy_reg ##1 done_reg && word_reg)
        else $error("word op not two clocks");
    a_word_plus_val: assert property (
        byte_take(core_alu_pkg::op_word_plus_immediate) |=> ##1
        {result_hi_reg, result_lo_reg} ==
        16'({$past(dst_hi_val, 2), $past(dst_val, 2)} +
            {8'h00, $past(imm_val, 2)}))
        else $error("word sum wrong");
    a_sub_borrow: assert property (
        byte_take(core_alu_pkg::op_sub) |=>
        flags_reg[`FLAG_C] == ($past(byte_if.b) > $past(dst_val)))
        else $error("sub carry wrong");
    a_sbc_result: assert property (
        byte_take(core_alu_pkg::op_difference_with_borrow) |=>
        result_lo_reg == 8'($past(dst_val) - $past(byte_if.b) -
                            {7'h00, $past(flags_reg[`FLAG_C])}))
        else $error("borrow sub wrong");
    a_word_minus_c: assert property (
        byte_take(core_alu_pkg::op_word_minus_immediate) |=> ##1
        flags_reg[`FLAG_C] == ({$past(dst_hi_val, 2), $past(dst_val, 2)}
                               < {8'h00, $past(imm_val, 2)}))
        else $error("word borrow wrong");
    a_and_flags: assert property (
        byte_take(core_alu_pkg::op_and) |=> !flags_reg[`FLAG_V] &&
        flags_reg[`FLAG_N] == result_lo_reg[7] &&
        $stable(flags_reg[`FLAG_C]))
        else $error("and flags wrong");
    a_or_result: assert property (
        byte_take(core_alu_pkg::op_or) |=>
        result_lo_reg == ($past(dst_val) | $past(byte_if.b)))
        else $error("or result wrong");
    a_xor_zero: assert property (
        byte_take(core_alu_pkg::op_exclusive_disjunction) |=>
        flags_reg[`FLAG_Z] == ($past(dst_val) == $past(src_val)))
        else $error("xor zero flag wrong");
    a_com_carry: assert property (
        byte_take(core_alu_pkg::op_bit_inversion) |=>
        flags_reg[`FLAG_C] && result_lo_reg == ~$past(dst_val))
        else $error("one's complement wrong");
    a_neg_carry: assert property (
        byte_take(core_alu_pkg::op_arithmetic_inversion) |=>
        flags_reg[`FLAG_C] == (result_lo_reg != `ALL_ZERO))
        else $error("two's complement carry wrong");
    a_clear_bits: assert property (
        byte_take(core_alu_pkg::op_clear_selected_bits) |=>
        result_lo_reg == ($past(dst_val) & ~$past(imm_val)))
        else $error("bit clear wrong");
    a_inc_carry: assert property (
        byte_take(core_alu_pkg::op_increment) |=> $stable(flags_reg[`FLAG_C]))
        else $error("increment touched carry");
    a_unlisted_kept: assert property (
        take && !is_word && op_code != core_alu_pkg::op_add |=>
        $stable(flags_reg[`FLAG_S]))
        else $error("sign flag changed by byte op");

    c_word_minus: cover property (
        byte_take(core_alu_pkg::op_word_minus_immediate) ##2 done_reg);
    c_add_carry: cover property (
        byte_take(core_alu_pkg::op_add_carry) ##1 flags_reg[`FLAG_H]);
    c_back_to_back: cover property (take ##1 take ##1 take);

endmodule // core_arith_logic_ops

`default_nettype wire

/* File: core_alu_cfg.svh */
/*
 * Constants of the arithmetic and logic unit: flag positions, update
 * masks, byte constants and reset values.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef CORE_ALU_CFG_SVH
`define CORE_ALU_CFG_SVH

`define FLAG_W       6
`define FLAG_C       0
`define FLAG_Z       1
`define FLAG_N       2
`define FLAG_V       3
`define FLAG_S       4
`define FLAG_H       5
`define FLAGS_RST    6'h00
`define UPD_NONE     6'h00
`define UPD_ARITH    6'h2F
`define UPD_WORD     6'h1F
`define UPD_LOGIC    6'h0E
`define UPD_COM      6'h0F
`define UPD_INC      6'h0E
`define ALL_ONES     8'hFF
`define ALL_ZERO     8'h00
`define ONE_BYTE     8'h01
`define SIGN_MIN     8'h80
`define BYTE_RST     8'h00
`define WORD_ZERO    16'h0000

`endif

/* File: core_alu_pkg.sv */
/*
 * Types of the arithmetic and logic unit: operation codes and states.
 * Assumes nothing of its surroundings.
 */
package core_alu_pkg;

    typedef enum logic [3:0] {
        op_add                    = 4'h0,
        op_add_carry              = 4'h1,
        op_sub                    = 4'h2,
        op_difference_with_borrow = 4'h3,
        op_and                    = 4'h4,
        op_or                     = 4'h5,
        op_exclusive_disjunction  = 4'h6,
        op_bit_inversion          = 4'h7,
        op_arithmetic_inversion   = 4'h8,
        op_set_selected_bits      = 4'h9,
        op_clear_selected_bits    = 4'hA,
        op_increment              = 4'hB,
        op_word_plus_immediate    = 4'hC,
        op_word_minus_immediate   = 4'hD
    } op_t;

    typedef enum logic {
        st_idle    = 1'b0,
        st_word_hi = 1'b1
    } state_t;

endpackage

/* File: alu_byte_if.sv */
/*
 * Carrier between the unit's sequencer and its byte datapath.
 * Assumes a purely combinational byte datapath on the unit side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "core_alu_cfg.svh"

interface alu_byte_if;
    core_alu_pkg::op_t    op;
    logic [7:0]           a;
    logic [7:0]           b;
    logic                 cin;
    logic [7:0]           result;
    logic [`FLAG_W-1:0]   flags_new;
    logic [`FLAG_W-1:0]   flags_upd;

    modport core (output op, a, b, cin,
                  input result, flags_new, flags_upd);
    modport unit (input op, a, b, cin,
                  output result, flags_new, flags_upd);
endinterface

`default_nettype wire

/* File: arith_byte_unit.sv */
/*
 * Combinational byte datapath: result, new flags and which flags change.
 * Assumes the caller merges the flags and registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "core_alu_cfg.svh"

module arith_byte_unit (
    alu_byte_if.unit port_if
);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic [2:0] hvc;
    logic [`FLAG_W-1:0] upd;

    // Half carry, overflow, carry of a sum
    function automatic logic [2:0] add_hvc(input logic [7:0] x,
                                           input logic [7:0] y,
                                           input logic [7:0] s);
        add_hvc[2] = x[3] & y[3] | y[3] & ~s[3] | ~s[3] & x[3];
        add_hvc[1] = x[7] & y[7] & ~s[7] | ~x[7] & ~y[7] & s[7];
        add_hvc[0] = x[7] & y[7] | y[7] & ~s[7] | ~s[7] & x[7];
    endfunction

    // Same for a difference; carry means borrow
    function automatic logic [2:0] sub_hvc(input logic [7:0] x,
                                           input logic [7:0] y,
                                           input logic [7:0] s);
        sub_hvc[2] = ~x[3] & y[3] | y[3] & s[3] | s[3] & ~x[3];
        sub_hvc[1] = x[7] & ~y[7] & ~s[7] | ~x[7] & y[7] & s[7];
        sub_hvc[0] = ~x[7] & y[7] | y[7] & s[7] | s[7] & ~x[7];
    endfunction

    assign a = port_if.a;
    assign b = port_if.b;

    always_comb begin
        r   = a;
        hvc = 3'h0;
        upd = `UPD_LOGIC;
        case (port_if.op)
            core_alu_pkg::op_add: begin
                r   = 8'(a + b);
                hvc = add_hvc(a, b, r);
                upd = `UPD_ARITH;
            end
            core_alu_pkg::op_add_carry: begin
                r   = 8'(a + b + {7'h00, port_if.cin});
                hvc = add_hvc(a, b, r);
                upd = `UPD_ARITH;
            end
            core_alu_pkg::op_sub: begin
                r   = 8'(a - b);
                hvc = sub_hvc(a, b, r);
                upd = `UPD_ARITH;
            end
            core_alu_pkg::op_difference_with_borrow: begin
                r   = 8'(a - b - {7'h00, port_if.cin});
                hvc = sub_hvc(a, b, r);
                upd = `UPD_ARITH;
            end
            core_alu_pkg::op_and:                   r = a & b;
            core_alu_pkg::op_or:                    r = a | b;
            core_alu_pkg::op_exclusive_disjunction: r = a ^ b;
            core_alu_pkg::op_set_selected_bits:     r = a | b;
            core_alu_pkg::op_clear_selected_bits:
                r = a & 8'(`ALL_ONES - b);
            core_alu_pkg::op_bit_inversion: begin
                r   = 8'(`ALL_ONES - a);
                hvc = 3'h1;
                upd = `UPD_COM;
            end
            core_alu_pkg::op_arithmetic_inversion: begin
                r   = 8'(`ALL_ZERO - a);
                hvc = sub_hvc(`ALL_ZERO, a, r);
                upd = `UPD_ARITH;
            end
            core_alu_pkg::op_increment: begin
                r   = 8'(a + `ONE_BYTE);
                hvc = {1'b0, r == `SIGN_MIN, 1'b0};
                upd = `UPD_INC;
            end
            default: begin
                r   = a;
                upd = `UPD_NONE;
            end
        endcase
    end

    always_comb begin
        port_if.flags_new          = `FLAGS_RST;
        port_if.flags_new[`FLAG_C] = hvc[0];
        port_if.flags_new[`FLAG_Z] = (r == `ALL_ZERO);
        port_if.flags_new[`FLAG_N] = r[7];
        port_if.flags_new[`FLAG_V] = hvc[1];
        port_if.flags_new[`FLAG_S] = r[7] ^ hvc[1];
        port_if.flags_new[`FLAG_H] = hvc[2];
    end

    assign port_if.result    = r;
    assign port_if.flags_upd = upd;

endmodule // arith_byte_unit

`default_nettype wire

/* File: decoder_model.sv */
/*
 * Decoder-side model: presents one request and holds it until taken.
 * Assumes its tasks are called just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module decoder_model (
    input  wire logic              ref_clk,
    input  wire logic              busy_reg,
    output var  logic              op_valid,
    output var  core_alu_pkg::op_t op_code,
    output var  logic              op_use_imm,
    output var  logic [7:0]        dst_val,
    output var  logic [7:0]        dst_hi_val,
    output var  logic [7:0]        src_val,
    output var  logic [7:0]        imm_val
);
    bit timed_out = 1'b0;

    initial begin
        op_valid   = 1'b0;
        op_code    = core_alu_pkg::op_add;
        op_use_imm = 1'b0;
        {dst_hi_val, dst_val, src_val, imm_val} = 32'h5A5A_A5A5;
    end

    // Unused operand port gets the inverse, never a stale copy
    task automatic drive(input logic [3:0] op, input logic imm,
                         input logic [15:0] w, input logic [7:0] b);
        op_valid   <= 1'b1;
        op_code    <= core_alu_pkg::op_t'(op);
        op_use_imm <= imm;
        {dst_hi_val, dst_val} <= w;
        src_val    <= imm ? ~b : b;
        imm_val    <= imm ? b : ~b;
    endtask

    // Holds the request until an edge sees busy_reg low
    task automatic issue(input logic [3:0] op, input logic imm,
                         input logic [15:0] w, input logic [7:0] b);
        int n;
        drive(op, imm, w, b);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (busy_reg !== 1'b0 && n < 8);
        if (busy_reg !== 1'b0)
            timed_out = 1'b1;
    endtask

    // Released operands change, so a late sample cannot pass
    task automatic release_req();
        op_valid <= 1'b0;
        {dst_hi_val, dst_val, src_val, imm_val} <=
            ~{dst_hi_val, dst_val, src_val, imm_val};
    endtask
endmodule // decoder_model

`default_nettype wire

/* File: test_core_arith_logic_ops.sv */
/*
 * Bench of the arithmetic and logic unit: operation table, then
 * back-to-back, undefined, busy-time and reset cases.
 * Assumes decoder_model for the request handshake.
 */
`timescale 1ns/1ps
`default_nettype none

module test_core_arith_logic_ops;
    typedef struct {
        logic [3:0]  op;
        logic        imm;
        logic [15:0] w;
        logic [7:0]  b;
        logic [15:0] r;
        logic [5:0]  m;
        logic [5:0]  f;
    } row_t;

    logic              ref_clk;
    logic              rst;
    logic              op_valid;
    core_alu_pkg::op_t op_code;
    logic              op_use_imm;
    logic [7:0]        dst_val;
    logic [7:0]        dst_hi_val;
    logic [7:0]        src_val;
    logic [7:0]        imm_val;
    logic              busy_reg;
    logic              done_reg;
    logic              word_reg;
    logic [7:0]        result_lo_reg;
    logic [7:0]        result_hi_reg;
    logic [5:0]        flags_reg;
    logic [5:0]        exp_f;
    int                err_total;
    int                n_tests;
    row_t              rows [19];

    core_arith_logic_ops dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .op_valid(op_valid),
        .op_code(op_code),
        .op_use_imm(op_use_imm),
        .dst_val(dst_val),
        .dst_hi_val(dst_hi_val),
        .src_val(src_val),
        .imm_val(imm_val),
        .busy_reg(busy_reg),
        .done_reg(done_reg),
        .word_reg(word_reg),
        .result_lo_reg(result_lo_reg),
        .result_hi_reg(result_hi_reg),
        .flags_reg(flags_reg)
    );

    decoder_model dec (
        .ref_clk(ref_clk),
        .busy_reg(busy_reg),
        .op_valid(op_valid),
        .op_code(op_code),
        .op_use_imm(op_use_imm),
        .dst_val(dst_val),
        .dst_hi_val(dst_hi_val),
        .src_val(src_val),
        .imm_val(imm_val)
    );

    task automatic summarize();
        // A request that never got through counts as a failure
        if (dec.timed_out)
            err_total++;
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        cmp({8'h00, g}, {8'h00, e});
    endtask

    task automatic chk6(input logic [5:0] g, input logic [5:0] e);
        cmp({10'h000, g}, {10'h000, e});
    endtask

    task automatic chk1(input logic g, input logic e);
        cmp({15'h0000, g}, {15'h0000, e});
    endtask

    // Latency counted in edges from the take edge
    task automatic wait_done(input int lat_exp);
        int lat;
        lat = 1;
        #1;
        chk1(busy_reg, lat_exp == 2);
        while (done_reg !== 1'b1 && lat < 6) begin
            @(posedge ref_clk);
            #1;
            lat++;
        end
        chk8(8'(lat), 8'(lat_exp));
        if (lat >= 6 || dec.timed_out) begin
            err_total++;
            summarize();
        end
    endtask

    // Only flags under the row's mask may move
    task automatic run(input row_t r);
        logic w;
        w = (r.m == 6'h1F);
        @(posedge ref_clk);
        dec.issue(r.op, r.imm, r.w, r.b);
        dec.release_req();
        wait_done(w ? 2 : 1);
        exp_f = (exp_f & ~r.m) | (r.f & r.m);
        chk8(result_lo_reg, r.r[7:0]);
        if (w)
            chk8(result_hi_reg, r.r[15:8]);
        chk1(word_reg, w);
        chk6(flags_reg, exp_f);
    endtask

    task automatic chk_rst();
        chk1(busy_reg, 1'b0);
        chk1(done_reg, 1'b0);
        chk1(word_reg, 1'b0);
        chk8(result_lo_reg, 8'h00);
        chk8(result_hi_reg, 8'h00);
        chk6(flags_reg, 6'h00);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        err_total = 0;
        n_tests = 0;
        exp_f = 6'h00;
        rst = 1'b1;
        rows = '{
            '{4'h0, 1'b0, 16'h000F, 8'h01, 16'h0010, 6'h2F, 6'h20},
            '{4'hC, 1'b1, 16'hFFFF, 8'h01, 16'h0000, 6'h1F, 6'h03},
            '{4'h0, 1'b0, 16'h00FF, 8'h01, 16'h0000, 6'h2F, 6'h23},
            '{4'h4, 1'b0, 16'h00F0, 8'h8F, 16'h0080, 6'h0E, 6'h04},
            '{4'h1, 1'b0, 16'h0010, 8'h20, 16'h0031, 6'h2F, 6'h00},
            '{4'h2, 1'b0, 16'h0000, 8'h01, 16'h00FF, 6'h2F, 6'h25},
            '{4'h5, 1'b1, 16'h0000, 8'h00, 16'h0000, 6'h0E, 6'h02},
            '{4'h3, 1'b1, 16'h0080, 8'h00, 16'h007F, 6'h2F, 6'h28},
            '{4'h3, 1'b0, 16'h0005, 8'h05, 16'h0000, 6'h2F, 6'h02},
            '{4'h2, 1'b1, 16'h0010, 8'h01, 16'h000F, 6'h2F, 6'h20},
            '{4'h6, 1'b0, 16'h00AA, 8'hAA, 16'h0000, 6'h0E, 6'h02},
            '{4'h7, 1'b0, 16'h007F, 8'h00, 16'h0080, 6'h0F, 6'h05},
            '{4'h8, 1'b0, 16'h0080, 8'h00, 16'h0080, 6'h2F, 6'h0D},
            '{4'hB, 1'b0, 16'h007F, 8'h00, 16'h0080, 6'h0E, 6'h0C},
            '{4'h8, 1'b0, 16'h0000, 8'h00, 16'h0000, 6'h2F, 6'h02},
            '{4'h9, 1'b1, 16'h0001, 8'h80, 16'h0081, 6'h0E, 6'h04},
            '{4'hA, 1'b1, 16'h0081, 8'h80, 16'h0001, 6'h0E, 6'h00},
            '{4'hD, 1'b1, 16'h8000, 8'h01, 16'h7FFF, 6'h1F, 6'h18},
            '{4'h0, 1'b0, 16'h0001, 8'h01, 16'h0002, 6'h2F, 6'h00}
        };
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk_rst();
        foreach (rows[i])
            run(rows[i]);
        // Carry of the first op feeds the second, one cycle apart
        @(posedge ref_clk);
        dec.issue(4'h0, 1'b0, 16'h00FF, 8'h01);
        dec.issue(4'h1, 1'b0, 16'h0000, 8'h00);
        dec.release_req();
        wait_done(1);
        exp_f = 6'h10;
        chk8(result_lo_reg, 8'h01);
        chk6(flags_reg, exp_f);
        // Undefined code completes but moves no flag
        @(posedge ref_clk);
        dec.drive(4'hE, 1'b0, 16'h00FF, 8'h01);
        @(posedge ref_clk);
        dec.release_req();
        #1;
        chk1(done_reg, 1'b1);
        chk6(flags_reg, exp_f);
        // Request during the busy cycle must be dropped
        @(posedge ref_clk);
        dec.issue(4'hC, 1'b1, 16'h1234, 8'h05);
        dec.drive(4'h0, 1'b0, 16'h0001, 8'h01);
        #1;
        chk1(busy_reg, 1'b1);
        @(posedge ref_clk);
        dec.release_req();
        #1;
        chk1(done_reg, 1'b1);
        chk1(word_reg, 1'b1);
        chk8(result_hi_reg, 8'h12);
        chk8(result_lo_reg, 8'h39);
        chk6(flags_reg, 6'h00);
        @(posedge ref_clk);
        #1;
        chk1(done_reg, 1'b0);
        // Reset in mid word operation
        @(posedge ref_clk);
        dec.issue(4'hD, 1'b1, 16'h0100, 8'h01);
        dec.release_req();
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk_rst();
        @(posedge ref_clk);
        #1;
        chk1(done_reg, 1'b0);
        summarize();
    end
endmodule // test_core_arith_logic_ops

`default_nettype wire
